// ---- ims_params.svh ----
`ifndef IMS_PARAMS_SVH
`define IMS_PARAMS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define IMS_CLK_MHZ 125
`define IMS_HOLD_DLY_US 100000
`define IMS_HOLD_DLY_CYC (`IMS_HOLD_DLY_US * `IMS_CLK_MHZ)
`define IMS_BOOT_LATCH 2'h2

// ----------------------------------------
// synchroniser bit positions
// ----------------------------------------
`define IMS_NPIN 9
`define IMS_P_MODE 0
`define IMS_P_SLEEP 1
`define IMS_P_STEP 2
`define IMS_P_DIR 3
`define IMS_P_SHA 4
`define IMS_P_SHB 5
`define IMS_P_SHC 6
`define IMS_P_SHD 7
`define IMS_P_SHE 8

// ----------------------------------------
// serial registers
// ----------------------------------------
`define IMS_FRAME_BITS 16
`define IMS_ADDR_CTRL 7'h00
`define IMS_ADDR_SCALE 7'h01
`define IMS_ADDR_HOLD 7'h02
`define IMS_ADDR_STAT 7'h03
`define IMS_CTRL_RST 8'h06
`define IMS_SCALE_RST 8'hff
`define IMS_HOLD_RST 8'h80
`define IMS_CTRL_AUTO_BIT 4
`define IMS_CTRL_VREF_BIT 5
`define IMS_HW_CURRENT 8'hff

`endif

// ---- ims_pkg.sv ----
package ims_pkg;
	typedef enum logic {
		IMS_ST_IDLE,
		IMS_ST_SHIFT
	} ims_spi_st_e;
	typedef logic [9:0] ims_pos_t;
	typedef logic [3:0] ims_res_t;
endpackage

// ---- ims_indexer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ims_params.svh"

module ims_indexer (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic step_evt,
	input wire logic dir,
	input wire ims_pkg::ims_res_t res_mode,
	input wire logic auto_en,
	output ims_pkg::ims_pos_t pos_q
);
	// ----------------------------------------
	// resolution decode
	// ----------------------------------------
	// position counts 1024 per electrical cycle, so 1/256 moves one count
	function automatic logic [3:0] res_shift(input ims_pkg::ims_res_t r);
		case (r)
			4'h0, 4'h1: res_shift = 4'h8;
			4'h2, 4'h3: res_shift = 4'h7;
			4'h4: res_shift = 4'h6;
			4'h5: res_shift = 4'h5;
			4'h6: res_shift = 4'h4;
			4'h7: res_shift = 4'h3;
			4'h8: res_shift = 4'h2;
			4'h9: res_shift = 4'h1;
			4'ha: res_shift = 4'h0;
			default: res_shift = 4'h4;
		endcase
	endfunction

	logic [3:0] shift;
	logic [10:0] inc;
	logic [23:0] per_cnt_q;
	logic [23:0] per_q;
	logic [23:0] tick_cnt_q;
	logic [10:0] pend_q;
	logic dir_q;
	logic tick;
	logic [10:0] pend_d;
	ims_pkg::ims_pos_t pos_d;

	assign shift = res_shift(res_mode);
	assign inc = 11'h1 << shift;
	// sub-step spacing is the last step period split evenly
	assign tick = auto_en && (pend_q != 11'h0) && (tick_cnt_q >= (per_q >> shift));
	assign pend_d = pend_q + (step_evt ? inc : 11'h0) - (tick ? 11'h1 : 11'h0);
	assign pos_d = !auto_en ? (step_evt ? (dir ? pos_q + inc[9:0] : pos_q - inc[9:0]) : pos_q)
		: (tick ? (dir_q ? pos_q + 10'h1 : pos_q - 10'h1) : pos_q);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pos_q <= 10'h0;
			per_cnt_q <= 24'h0;
			per_q <= 24'h0;
			tick_cnt_q <= 24'h0;
			pend_q <= 11'h0;
			dir_q <= 1'b0;
		end else if (clk_en) begin
			pos_q <= pos_d;
			pend_q <= auto_en ? pend_d : 11'h0;
			per_cnt_q <= step_evt ? 24'h0 : (&per_cnt_q ? per_cnt_q : per_cnt_q + 24'h1);
			if (step_evt) begin
				per_q <= per_cnt_q;
				dir_q <= dir;
			end
			tick_cnt_q <= (tick || step_evt) ? 24'h0 : tick_cnt_q + 24'h1;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	step_advance_a: assert property ($past(clk_en && step_evt && !auto_en && dir)
		|-> pos_q == $past(pos_q) + $past(inc[9:0]))
		else $error("manual step did not advance by resolution");
	auto_queue_a: assert property ($past(clk_en && auto_en && step_evt && pend_q == 11'h0)
		|-> pend_q == $past(inc))
		else $error("auto step did not queue microsteps");
endmodule // ims_indexer

`default_nettype wire

// ---- ims_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ims_params.svh"

// Functional notes
// - interface select is sampled at power-up and at each sleep exit, and held until the next.
// - a low sample selects pin configuration taken from the strapping inputs.
// - a high sample selects the serial port with its extra features.
// - five shared pins carry strap inputs in pin mode; four of them carry serial signals in serial mode (shp_b is reserved).
// - serial mode has an 8-bit register scaling the regulated current.
// - serial mode has an 8-bit register setting the standstill holding current.
// - the indexer moves winding position from step and direction, full step to 1/256.
// - internal reference enable set to one selects the internal reference.
// - automatic microstepping splits slow input steps into fine internal steps.
// - a sleep state under external control stops driving the motor.
module ims_top #(
	parameter int HOLD_DLY_CYC = `IMS_HOLD_DLY_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic iface_sel,
	input wire logic sleep_ctrl_low,
	input wire logic step_in,
	input wire logic dir_in,
	input wire logic shp_a,
	input wire logic shp_b,
	input wire logic shp_c_i,
	input wire logic shp_d,
	input wire logic shp_e,
	output logic shp_c_o,
	output logic shp_c_oe,
	output logic spi_mode_q,
	output logic bridge_en_q,
	output ims_pkg::ims_res_t res_mode_q,
	output ims_pkg::ims_pos_t winding_pos_q,
	output logic [7:0] current_code_q,
	output logic standstill_q,
	output logic vref_int_q,
	output logic auto_step_q,
	output logic off_time_sel_q,
	output logic decay_sel_a_q,
	output logic decay_sel_b_q
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// shp_a: step_res_sel_a / serial_chip_sel_low, shp_b: off_time_sel / reserved,
	// shp_c: decay_sel_b / data out, shp_d: decay_sel_a / data in, shp_e: step_res_sel_b / clock
	logic [`IMS_NPIN-1:0] pin_raw;
	logic [`IMS_NPIN-1:0] s1_q;
	logic [`IMS_NPIN-1:0] s2_q;
	logic [`IMS_NPIN-1:0] s3_q;

	assign pin_raw = {shp_e, shp_d, shp_c_i, shp_b, shp_a, dir_in, step_in, sleep_ctrl_low, iface_sel};

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else if (clk_en) begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// ----------------------------------------
	// interface latch and sleep
	// ----------------------------------------
	logic [1:0] boot_q;
	logic asleep;
	logic sleep_exit;
	logic latch_evt;

	assign asleep = !s2_q[`IMS_P_SLEEP];
	assign sleep_exit = s2_q[`IMS_P_SLEEP] && !s3_q[`IMS_P_SLEEP];
	// boot sample waits until the synchroniser holds a real pin level
	assign latch_evt = (boot_q == `IMS_BOOT_LATCH) || sleep_exit;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			boot_q <= 2'h0;
			spi_mode_q <= 1'b0;
			bridge_en_q <= 1'b0;
		end else if (clk_en) begin
			boot_q <= (boot_q == 2'h3) ? boot_q : boot_q + 2'h1;
			if (latch_evt)
				spi_mode_q <= s2_q[`IMS_P_MODE];
			bridge_en_q <= !asleep && (boot_q == 2'h3);
		end
	end

	// ----------------------------------------
	// serial port
	// ----------------------------------------
	ims_pkg::ims_spi_st_e st_q;
	logic [3:0] bit_cnt_q;
	logic [`IMS_FRAME_BITS-1:0] rx_q;
	logic [`IMS_FRAME_BITS-1:0] tx_q;
	logic [7:0] rd_q;
	logic [7:0] ctrl_q;
	logic [7:0] scale_q;
	logic [7:0] hold_q;
	logic cs_active;
	logic cs_fall;
	logic sclk_rise;
	logic sclk_fall;
	logic frame_end;
	logic [`IMS_FRAME_BITS-1:0] frame;
	logic wr_en;
	logic [7:0] stat;

	// reserved pin (shp_b) is never read in serial mode
	assign cs_active = spi_mode_q && !s2_q[`IMS_P_SHA];
	assign cs_fall = cs_active && s3_q[`IMS_P_SHA];
	assign sclk_rise = s2_q[`IMS_P_SHE] && !s3_q[`IMS_P_SHE];
	assign sclk_fall = !s2_q[`IMS_P_SHE] && s3_q[`IMS_P_SHE];
	assign frame = {rx_q[`IMS_FRAME_BITS-2:0], s2_q[`IMS_P_SHD]};
	assign frame_end = (st_q == ims_pkg::IMS_ST_SHIFT) && cs_active && sclk_rise
		&& (bit_cnt_q == 4'hf);
	assign wr_en = frame_end && frame[15];
	assign stat = {5'h00, standstill_q, bridge_en_q, spi_mode_q};

	// unmapped addresses read zero and ignore writes
	function automatic logic [7:0] read_reg(input logic [6:0] a, input logic [7:0] c,
		input logic [7:0] s, input logic [7:0] h, input logic [7:0] st);
		case (a)
			`IMS_ADDR_CTRL: read_reg = c;
			`IMS_ADDR_SCALE: read_reg = s;
			`IMS_ADDR_HOLD: read_reg = h;
			`IMS_ADDR_STAT: read_reg = st;
			default: read_reg = 8'h00;
		endcase
	endfunction

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_q <= ims_pkg::IMS_ST_IDLE;
			bit_cnt_q <= 4'h0;
			rx_q <= '0;
			tx_q <= '0;
			rd_q <= 8'h00;
		end else if (clk_en) begin
			case (st_q)
				ims_pkg::IMS_ST_IDLE: begin
					if (cs_fall) begin
						st_q <= ims_pkg::IMS_ST_SHIFT;
						bit_cnt_q <= 4'h0;
						tx_q <= {stat, rd_q};
					end
				end
				ims_pkg::IMS_ST_SHIFT: begin
					if (!cs_active) begin
						st_q <= ims_pkg::IMS_ST_IDLE;
					end else if (sclk_rise) begin
						rx_q <= frame;
						bit_cnt_q <= bit_cnt_q + 4'h1;
						if (frame_end)
							rd_q <= read_reg(frame[14:8], ctrl_q, scale_q, hold_q, stat);
					end else if (sclk_fall) begin
						tx_q <= {tx_q[`IMS_FRAME_BITS-2:0], 1'b0};
					end
				end
				default: st_q <= ims_pkg::IMS_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl_q <= `IMS_CTRL_RST;
			scale_q <= `IMS_SCALE_RST;
			hold_q <= `IMS_HOLD_RST;
		end else if (clk_en && wr_en) begin
			if (frame[14:8] == `IMS_ADDR_CTRL)
				ctrl_q <= frame[7:0];
			if (frame[14:8] == `IMS_ADDR_SCALE)
				scale_q <= frame[7:0];
			if (frame[14:8] == `IMS_ADDR_HOLD)
				hold_q <= frame[7:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			shp_c_o <= 1'b0;
			shp_c_oe <= 1'b0;
		end else if (clk_en) begin
			shp_c_o <= tx_q[`IMS_FRAME_BITS-1];
			shp_c_oe <= cs_active && (st_q == ims_pkg::IMS_ST_SHIFT);
		end
	end

	// ----------------------------------------
	// configuration routing
	// ----------------------------------------
	ims_pkg::ims_res_t hw_res;
	logic step_evt;
	logic [23:0] idle_cnt_q;
	logic idle_done;

	// only driven levels are seen here; floating strap levels are not resolved
	assign hw_res = s2_q[`IMS_P_SHE] ? (s2_q[`IMS_P_SHA] ? 4'h5 : 4'h4)
		: (s2_q[`IMS_P_SHA] ? 4'h2 : 4'h0);
	assign step_evt = s2_q[`IMS_P_STEP] && !s3_q[`IMS_P_STEP] && bridge_en_q;
	assign idle_done = idle_cnt_q >= HOLD_DLY_CYC[23:0];

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			res_mode_q <= 4'h0;
			off_time_sel_q <= 1'b0;
			decay_sel_a_q <= 1'b0;
			decay_sel_b_q <= 1'b0;
			vref_int_q <= 1'b0;
			auto_step_q <= 1'b0;
		end else if (clk_en) begin
			res_mode_q <= spi_mode_q ? ctrl_q[3:0] : hw_res;
			off_time_sel_q <= !spi_mode_q && s2_q[`IMS_P_SHB];
			decay_sel_a_q <= !spi_mode_q && s2_q[`IMS_P_SHD];
			decay_sel_b_q <= !spi_mode_q && s2_q[`IMS_P_SHC];
			vref_int_q <= spi_mode_q && ctrl_q[`IMS_CTRL_VREF_BIT];
			auto_step_q <= spi_mode_q && ctrl_q[`IMS_CTRL_AUTO_BIT];
		end
	end

	// ----------------------------------------
	// current level and standstill
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			idle_cnt_q <= 24'h0;
			standstill_q <= 1'b0;
			current_code_q <= 8'h00;
		end else if (clk_en) begin
			idle_cnt_q <= step_evt ? 24'h0 : (idle_done ? idle_cnt_q : idle_cnt_q + 24'h1);
			standstill_q <= spi_mode_q && idle_done && !step_evt;
			if (!bridge_en_q)
				current_code_q <= 8'h00;
			else if (!spi_mode_q)
				current_code_q <= `IMS_HW_CURRENT;
			else
				current_code_q <= standstill_q ? hold_q : scale_q;
		end
	end

	ims_indexer u_indexer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.step_evt(step_evt),
		.dir(s2_q[`IMS_P_DIR]),
		.res_mode(res_mode_q),
		.auto_en(auto_step_q),
		.pos_q(winding_pos_q)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_latch;
		clk_en && latch_evt;
	endsequence

	mode_hold_a: assert property ($changed(spi_mode_q) |-> $past(latch_evt && clk_en))
		else $error("interface changed without a latch event");
	mode_sample_a: assert property (s_latch |=> spi_mode_q == $past(s2_q[`IMS_P_MODE]))
		else $error("interface not taken from select pin");
	hw_strap_a: assert property ($past(clk_en && !spi_mode_q)
		|-> off_time_sel_q == $past(s2_q[`IMS_P_SHB]))
		else $error("strap not routed in pin mode");
	spi_feat_a: assert property (!$past(spi_mode_q) && $past(clk_en)
		|-> !auto_step_q && !vref_int_q)
		else $error("serial feature active in pin mode");
	sdo_drive_a: assert property ($past(clk_en) && !$past(cs_active) |-> !shp_c_oe)
		else $error("data out driven without chip select");
	hw_sdo_off_a: assert property ($past(clk_en) && !$past(spi_mode_q) |-> !shp_c_oe)
		else $error("data out driven in pin mode");
	scale_use_a: assert property ($past(clk_en && bridge_en_q && spi_mode_q && !standstill_q)
		|-> current_code_q == $past(scale_q))
		else $error("scale register not applied");
	hold_use_a: assert property ($past(clk_en && bridge_en_q && spi_mode_q && standstill_q)
		|-> current_code_q == $past(hold_q))
		else $error("holding current not applied");
	vref_sel_a: assert property ($past(clk_en)
		|-> vref_int_q == $past(spi_mode_q && ctrl_q[`IMS_CTRL_VREF_BIT]))
		else $error("internal reference select wrong");
	sleep_off_a: assert property ($past(clk_en && asleep) |-> !bridge_en_q)
		else $error("bridges enabled while asleep");
endmodule // ims_top

`default_nettype wire

// ---- ims_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module ims_ctrl_model (
	input wire logic core_clk,
	input wire logic shp_c_o,
	input wire logic shp_c_oe,
	output var logic iface_sel,
	output var logic sleep_ctrl_low,
	output var logic step_in,
	output var logic dir_in,
	output logic shp_a,
	output logic shp_b,
	output logic shp_c_i,
	output logic shp_d,
	output logic shp_e
);
	// ----------------------------------------
	// shared pin drive
	// ----------------------------------------
	logic [4:0] straps_q = 5'h00;
	logic serial_chip_sel_low_q = 1'b1;
	logic sclk_q = 1'b0;
	logic sdi_q = 1'b0;
	logic rsv_q = 1'b0;
	logic sdo_last_q = 1'b0;

	initial begin
		iface_sel = 1'b0;
		sleep_ctrl_low = 1'b1;
		step_in = 1'b0;
		dir_in = 1'b1;
	end

	// released data line shows the inverse of its last value, never a held copy
	assign shp_c_i = shp_c_oe ? shp_c_o : (iface_sel ? ~sdo_last_q : straps_q[2]);
	assign shp_a = iface_sel ? serial_chip_sel_low_q : straps_q[0];
	assign shp_b = iface_sel ? rsv_q : straps_q[1];
	assign shp_d = iface_sel ? sdi_q : straps_q[3];
	assign shp_e = iface_sel ? sclk_q : straps_q[4];

	// reserved pin wiggles every cycle so a device that listens to it shows it
	always @(posedge core_clk) begin
		rsv_q <= ~rsv_q;
		if (shp_c_oe)
			sdo_last_q <= shp_c_o;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic set_straps(input logic [4:0] v);
		@(posedge core_clk);
		straps_q <= v;
	endtask

	task automatic set_sleep(input logic awake);
		@(posedge core_clk);
		sleep_ctrl_low <= awake;
		tick(8);
	endtask

	// select level only moves while asleep
	task automatic set_iface(input logic sel);
		@(posedge core_clk);
		if (!sleep_ctrl_low)
			iface_sel <= sel;
		tick(8);
	endtask

	// direction setup kept near 200 ns and pulse widths near a microsecond, as the pin asks
	task automatic step(input logic up);
		@(posedge core_clk);
		dir_in <= up;
		tick(26);
		step_in <= 1'b1;
		tick(125);
		step_in <= 1'b0;
		tick(125);
	endtask

	task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
		@(posedge core_clk);
		serial_chip_sel_low_q <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdi_q <= tx[i];
			tick(8);
			sclk_q <= 1'b1;
			tick(8);
			rx[i] = shp_c_i;
			sclk_q <= 1'b0;
		end
		tick(8);
		serial_chip_sel_low_q <= 1'b1;
		tick(8);
	endtask
endmodule // ims_ctrl_model

`default_nettype wire

// ---- ims_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ims_params.svh"

module tb_top;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic iface_sel, sleep_ctrl_low, step_in, dir_in;
	logic shp_a, shp_b, shp_c_i, shp_d, shp_e, shp_c_o, shp_c_oe;
	logic spi_mode_q, bridge_en_q, standstill_q, vref_int_q, auto_step_q;
	logic off_time_sel_q, decay_sel_a_q, decay_sel_b_q;
	ims_pkg::ims_res_t res_mode_q;
	ims_pkg::ims_pos_t winding_pos_q;
	logic [7:0] current_code_q;
	int n_errors = 0;
	int compares = 0;

	always #4 core_clk = ~core_clk;

	// ----------------------------------------
	// device and controller
	// ----------------------------------------
	ims_top #(.HOLD_DLY_CYC(600)) i_dut (
		.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .iface_sel(iface_sel),
		.sleep_ctrl_low(sleep_ctrl_low), .step_in(step_in), .dir_in(dir_in),
		.shp_a(shp_a), .shp_b(shp_b), .shp_c_i(shp_c_i), .shp_d(shp_d), .shp_e(shp_e),
		.shp_c_o(shp_c_o), .shp_c_oe(shp_c_oe), .spi_mode_q(spi_mode_q),
		.bridge_en_q(bridge_en_q), .res_mode_q(res_mode_q), .winding_pos_q(winding_pos_q),
		.current_code_q(current_code_q), .standstill_q(standstill_q),
		.vref_int_q(vref_int_q), .auto_step_q(auto_step_q), .off_time_sel_q(off_time_sel_q),
		.decay_sel_a_q(decay_sel_a_q), .decay_sel_b_q(decay_sel_b_q));

	ims_ctrl_model i_model (
		.core_clk(core_clk), .shp_c_o(shp_c_o), .shp_c_oe(shp_c_oe), .iface_sel(iface_sel),
		.sleep_ctrl_low(sleep_ctrl_low), .step_in(step_in), .dir_in(dir_in),
		.shp_a(shp_a), .shp_b(shp_b), .shp_c_i(shp_c_i), .shp_d(shp_d), .shp_e(shp_e));

	task automatic stop_test();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_pos(input logic [9:0] exp, input int lim);
		int n;
		n = 0;
		while (winding_pos_q !== exp && n < lim) begin
			@(posedge core_clk);
			n++;
		end
		chk("winding_pos_q", exp, winding_pos_q);
		if (winding_pos_q !== exp)
			stop_test();
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] rx;
		i_model.frame({1'b1, a, d}, rx);
	endtask

	// read data comes back one frame late
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		logic [15:0] rx;
		i_model.frame({1'b0, a, 8'h00}, rx);
		i_model.frame({1'b0, `IMS_ADDR_STAT, 8'h00}, rx);
		d = rx[7:0];
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic pin_mode_test();
		logic [9:0] p;
		i_model.tick(20);
		chk("spi_mode_q", 10'h000, spi_mode_q);
		chk("current_code_q", `IMS_HW_CURRENT, current_code_q);
		// uneven strap pattern catches swapped shared pins
		i_model.set_straps(5'h0b);
		i_model.tick(10);
		chk("res_mode_q", 10'h002, res_mode_q);
		chk("straps", 10'h006, {off_time_sel_q, decay_sel_a_q, decay_sel_b_q});
		i_model.set_straps(5'h1f);
		i_model.tick(10);
		chk("res_mode_q", 10'h005, res_mode_q);
		chk("straps", 10'h007, {off_time_sel_q, decay_sel_a_q, decay_sel_b_q});
		p = winding_pos_q;
		i_model.step(1'b1);
		wait_pos(p + 10'h020, 400);
		i_model.set_straps(5'h00);
		i_model.step(1'b0);
		wait_pos(p - 10'h0e0, 400);
		chk("shp_c_oe", 10'h000, shp_c_oe);
	endtask

	task automatic sleep_test();
		logic [9:0] p;
		i_model.set_sleep(1'b0);
		i_model.tick(10);
		chk("bridge_en_q", 10'h000, bridge_en_q);
		chk("current_code_q", 10'h000, current_code_q);
		p = winding_pos_q;
		i_model.step(1'b1);
		chk("winding_pos_q", p, winding_pos_q);
		i_model.set_iface(1'b1);
		i_model.set_sleep(1'b1);
		i_model.tick(700);
		chk("spi_mode_q", 10'h001, spi_mode_q);
		chk("off_time_sel_q", 10'h000, off_time_sel_q);
	endtask

	task automatic serial_test();
		logic [15:0] rx;
		logic [7:0] d;
		i_model.frame({1'b0, `IMS_ADDR_STAT, 8'h00}, rx);
		chk("status", 10'h007, rx[15:8]);
		rd(`IMS_ADDR_SCALE, d);
		chk("scale", `IMS_SCALE_RST, d);
		rd(`IMS_ADDR_HOLD, d);
		chk("hold", `IMS_HOLD_RST, d);
		chk("current_code_q", `IMS_HOLD_RST, current_code_q);
		wr(`IMS_ADDR_HOLD, 8'h20);
		i_model.tick(4);
		chk("current_code_q", 10'h020, current_code_q);
		wr(`IMS_ADDR_SCALE, 8'h40);
		i_model.step(1'b1);
		chk("current_code_q", 10'h040, current_code_q);
		wr(7'h10, 8'h55);
		rd(7'h10, d);
		chk("unmapped", 10'h000, d);
		wr(`IMS_ADDR_CTRL, 8'h26);
		i_model.tick(4);
		chk("vref_int_q", 10'h001, vref_int_q);
		chk("standstill_q", 10'h001, standstill_q);
		chk("current_code_q", 10'h020, current_code_q);
	endtask

	task automatic res_test();
		logic [9:0] p;
		logic [9:0] inc;
		for (int c = 0; c < 11; c++) begin
			wr(`IMS_ADDR_CTRL, 8'(c));
			p = winding_pos_q;
			inc = (c < 2) ? 10'h100 : (c < 4) ? 10'h080 : 10'(11'h400 >> c);
			i_model.step(1'b1);
			wait_pos(p + inc, 400);
			chk("res_mode_q", 10'(c), res_mode_q);
		end
	endtask

	task automatic auto_test();
		logic [9:0] p;
		logic fine;
		int n;
		wr(`IMS_ADDR_CTRL, 8'h14);
		i_model.tick(4);
		chk("auto_step_q", 10'h001, auto_step_q);
		p = winding_pos_q;
		fine = 1'b0;
		n = 0;
		fork
			repeat (3) i_model.step(1'b1);
			while (winding_pos_q !== p + 10'h0c0 && n < 6000) begin
				@(posedge core_clk);
				if (winding_pos_q[5:0] !== p[5:0])
					fine = 1'b1;
				n++;
			end
		join
		chk("fine_steps", 10'h001, fine);
		wait_pos(p + 10'h0c0, 6000);
		chk("spi_mode_q", 10'h001, spi_mode_q);
	endtask

	// a step pulse that lies wholly inside a freeze must be lost
	task automatic freeze_test();
		logic [9:0] p;
		logic [7:0] cur;
		p = winding_pos_q;
		cur = current_code_q;
		@(posedge core_clk);
		clk_en <= 1'b0;
		i_model.step(1'b1);
		chk("frozen_pos", p, winding_pos_q);
		chk("frozen_current", cur, current_code_q);
		@(posedge core_clk);
		clk_en <= 1'b1;
		i_model.tick(10);
		chk("winding_pos_q", p, winding_pos_q);
		i_model.step(1'b1);
		wait_pos(p + 10'h040, 6000);
	endtask

	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		pin_mode_test();
		sleep_test();
		serial_test();
		res_test();
		auto_test();
		freeze_test();
		stop_test();
	end
endmodule // tb_top

`default_nettype wire
